// >>> design/crmb_core_bank.sv
// core register group with apb access, mirrored in every bank
//
// How it works
// - counter upper byte only through the latch
// - latch copied into counter upper on load
// - latch seven bits, top zero, always cleared
// - group decodes identically in every bank
// - unimplemented locations and bits read zero
// - pointer0 high always clears, low power-on
// - pointer1 low power-on clears, high always
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
module crmb_core_bank #(
  parameter int RAM_DEPTH = 256
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // reset kind: high for power-on or brown-out
  input wire logic POR_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // core events from the datapath
  input wire logic PC_STEP_I,
  input wire logic [crmb_pkg::INTC_EVT_W-1:0] INT_EVT_I,
  input wire logic TIMEOUT_I,
  input wire logic POWERDOWN_I,
  // state seen by the core
  output logic [crmb_pkg::PC_W-1:0] PC_O,
  output logic [crmb_pkg::BANK_W-1:0] BANK_O,
  output logic [7:0] WORK_O,
  output logic [7:0] INTC_O
);
  // registers
  // pointer pairs for the indirect ports
  logic [7:0] p0l_q;
  logic [7:0] p0h_q;
  logic [7:0] p1l_q;
  logic [7:0] p1h_q;
  // core state visible to software
  logic [7:0] flags_q;
  logic [crmb_pkg::BANK_W-1:0] bank_q;
  logic [7:0] work_q;
  logic [crmb_pkg::LATCH_W-1:0] latch_q;
  logic [7:0] intc_q;
  logic [7:0] intc_d;
  // apb answer flip-flops
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  // counter from the pc unit
  logic [crmb_pkg::PC_W-1:0] pc_w;
  // memory read data for the indirect ports
  logic [7:0] ram_rdata;

  // refuse memory depths the pointer pairs cannot address;
  // the depth must also be a power of two for the index slice
  if (RAM_DEPTH < 2 || RAM_DEPTH > 65536 ||
    (RAM_DEPTH & (RAM_DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("crmb_core_bank: RAM_DEPTH must be a power of two");
  end

  // apb phases
  wire logic setup_w = PSEL_I && !PENABLE_I;
  // read data is looked up in the setup cycle
  wire logic rd_setup_w = setup_w && !PWRITE_I;
  // a write lands only at the edge that completes the access
  wire logic wr_w = PSEL_I && PENABLE_I && pready_q && PWRITE_I;
  // data index from the byte address
  wire logic [11:0] idx_w =
    PADDR_I[crmb_pkg::IDX_LSB +: crmb_pkg::IDX_W];
  // bank bits ignored
  // the index bits above the offset pick a bank; dropping them
  // makes the group answer at the same offset in every bank
  wire logic [6:0] ofs_w = idx_w[crmb_pkg::OFS_W-1:0];
  wire logic [7:0] wbyte_w = PWDATA_I[7:0];

  // register selects by in-bank offset
  wire logic sel_ind0 = (ofs_w == crmb_pkg::IDX_IND0[6:0]);
  wire logic sel_ind1 = (ofs_w == crmb_pkg::IDX_IND1[6:0]);
  wire logic sel_pcl = (ofs_w == crmb_pkg::IDX_PCL[6:0]);
  wire logic sel_flags = (ofs_w == crmb_pkg::IDX_FLAGS[6:0]);
  wire logic sel_p0l = (ofs_w == crmb_pkg::IDX_P0L[6:0]);
  wire logic sel_p0h = (ofs_w == crmb_pkg::IDX_P0H[6:0]);
  wire logic sel_p1l = (ofs_w == crmb_pkg::IDX_P1L[6:0]);
  wire logic sel_p1h = (ofs_w == crmb_pkg::IDX_P1H[6:0]);
  wire logic sel_bank = (ofs_w == crmb_pkg::IDX_BANK[6:0]);
  wire logic sel_work = (ofs_w == crmb_pkg::IDX_WORK[6:0]);
  wire logic sel_latch = (ofs_w == crmb_pkg::IDX_LATCH[6:0]);
  wire logic sel_intc = (ofs_w == crmb_pkg::IDX_INTC[6:0]);

  // per-register write strobes, all taken at the access edge;
  // writes to unmapped offsets match no strobe and are dropped
  wire logic we_p0l_w = wr_w && sel_p0l;
  wire logic we_p0h_w = wr_w && sel_p0h;
  wire logic we_p1l_w = wr_w && sel_p1l;
  wire logic we_p1h_w = wr_w && sel_p1h;
  wire logic we_flags_w = wr_w && sel_flags;
  wire logic we_bank_w = wr_w && sel_bank;
  wire logic we_work_w = wr_w && sel_work;
  wire logic we_latch_w = wr_w && sel_latch;
  wire logic we_intc_w = wr_w && sel_intc;
  // only a low-byte write loads the counter
  wire logic pc_load_w = wr_w && sel_pcl;

  wire logic [15:0] ptr0_w = {p0h_q, p0l_q};
  wire logic [15:0] ptr1_w = {p1h_q, p1l_q};
  wire logic [15:0] ind_addr_w = sel_ind1 ? ptr1_w : ptr0_w;
  wire logic ind_wr_w = wr_w && (sel_ind0 || sel_ind1);

  // read mux, one byte per offset
  // unmapped offsets and bits read zero
  wire logic [7:0] rbyte_w =
    (sel_ind0 || sel_ind1) ? ram_rdata :
    sel_pcl ? pc_w[7:0] :
    sel_flags ? flags_q :
    sel_p0l ? p0l_q :
    sel_p0h ? p0h_q :
    sel_p1l ? p1l_q :
    sel_p1h ? p1h_q :
    sel_bank ? {3'h0, bank_q} :
    sel_work ? work_q :
    sel_latch ? {1'h0, latch_q} :
    sel_intc ? intc_q : 8'h00;

  // apb answer: ready in the first access cycle, never an error
  // zero wait states: ready follows every setup by one cycle, and
  // the read byte is held until the next read setup replaces it
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup_w;
      pslverr_q <= 1'b0;
      // read data captured during setup
      if (rd_setup_w)
        prdata_q <= {24'h00_0000, rbyte_w};
    end
  end

  // pointer 0 reset split by kind
  // the low byte rides through a warm reset so a pointer that
  // software set up survives a restart; the high byte never does
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      p0h_q <= crmb_pkg::BYTE_ZERO;
      if (POR_I)
        p0l_q <= crmb_pkg::BYTE_ZERO;
    end
    else
    begin
      if (we_p0l_w)
        p0l_q <= wbyte_w;
      if (we_p0h_w)
        p0h_q <= wbyte_w;
    end
  end

  // pointer 1 reset split by kind
  // same split as pointer 0, low byte kept on a warm reset
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      p1h_q <= crmb_pkg::BYTE_ZERO;
      if (POR_I)
        p1l_q <= crmb_pkg::BYTE_ZERO;
    end
    else
    begin
      if (we_p1l_w)
        p1l_q <= wbyte_w;
      if (we_p1h_w)
        p1h_q <= wbyte_w;
    end
  end

  // latch seven bits, cleared on any reset
  // bit seven is never stored, so it can only read zero
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      latch_q <= crmb_pkg::LATCH_RST;
    else if (we_latch_w)
      latch_q <= wbyte_w[crmb_pkg::LATCH_W-1:0];
  end

  // bank select clears on any reset, five bits kept
  // the three top bits are not stored and read as zero
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      bank_q <= crmb_pkg::BANK_RST;
    else if (we_bank_w)
      bank_q <= wbyte_w[crmb_pkg::BANK_W-1:0];
  end

  // working register clears on power-on only
  // a warm reset leaves the working byte as software left it
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      if (POR_I)
        work_q <= crmb_pkg::BYTE_ZERO;
    end
    else if (we_work_w)
      work_q <= wbyte_w;
  end

  // flags: timeout and power-down follow hardware, low three writable
  // the two status bits record why the last warm reset came
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      // other resets keep the arithmetic flags
      if (POR_I)
        flags_q <= crmb_pkg::FLAGS_POR;
      else
      begin
        flags_q[crmb_pkg::FLAGS_TO] <= !TIMEOUT_I;
        flags_q[crmb_pkg::FLAGS_PD] <= !POWERDOWN_I;
      end
    end
    else if (we_flags_w)
      flags_q[crmb_pkg::FLAGS_WR_W-1:0] <=
        wbyte_w[crmb_pkg::FLAGS_WR_W-1:0];
  end

  // interrupt control next value: event set wins over a write
  // so a flag raised while software clears it is never lost
  always_comb
  begin
    intc_d = intc_q;
    if (we_intc_w)
      intc_d = wbyte_w;
    intc_d[crmb_pkg::INTC_EVT_W-1:0] =
      intc_d[crmb_pkg::INTC_EVT_W-1:0] | INT_EVT_I;
  end

  // interrupt control: enables clear, lowest flag kept off power-on
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      intc_q[7:1] <= 7'h00;
      if (POR_I)
        intc_q[0] <= 1'b0;
    end
    else
      intc_q <= intc_d;
  end

  // indirect data memory
  // one address serves both ports of the memory: a transfer is
  // either a read or a write, never both
  // pointers past the array are refused inside the memory
  crmb_data_ram #(
    .DEPTH (RAM_DEPTH)
  ) u_ram (
    .clk_i (CLOCK_I),
    .we_i (ind_wr_w),
    .waddr_i (ind_addr_w),
    .wdata_i (wbyte_w),
    .raddr_i (ind_addr_w),
    .rdata_o (ram_rdata)
  );

  // counter upper only loaded from latch
  // no offset decodes to the upper byte, so no write reaches it
  crmb_pc_unit u_pc (
    .clk_i (CLOCK_I),
    .rst_i (RST_I),
    .load_i (pc_load_w),
    .low_i (wbyte_w),
    .latch_i (latch_q),
    .step_i (PC_STEP_I),
    .pc_o (pc_w)
  );

  // outputs straight from flip-flops
  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign PC_O = pc_w;
  assign BANK_O = bank_q;
  assign WORK_O = work_q;
  assign INTC_O = intc_q;
endmodule : crmb_core_bank

// >>> common/crmb_pkg.sv
// constants shared by the core register mirror bank
package crmb_pkg;
  // printed register offsets (bank 31 view), used as data indices
  localparam logic [11:0] IDX_IND0 = 12'hf80;
  localparam logic [11:0] IDX_IND1 = 12'hf81;
  localparam logic [11:0] IDX_PCL = 12'hf82;
  localparam logic [11:0] IDX_FLAGS = 12'hf83;
  localparam logic [11:0] IDX_P0L = 12'hf84;
  localparam logic [11:0] IDX_P0H = 12'hf85;
  localparam logic [11:0] IDX_P1L = 12'hf86;
  localparam logic [11:0] IDX_P1H = 12'hf87;
  localparam logic [11:0] IDX_BANK = 12'hf88;
  localparam logic [11:0] IDX_WORK = 12'hf89;
  localparam logic [11:0] IDX_LATCH = 12'hf8a;
  localparam logic [11:0] IDX_INTC = 12'hf8b;
  // offset bits that select a register inside one bank
  localparam int OFS_W = 7;
  // data index sits at byte address bits 13:2
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 12;
  // values after power-on or brown-out reset
  localparam logic [7:0] FLAGS_POR = 8'h18;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [6:0] LATCH_RST = 7'h00;
  localparam logic [4:0] BANK_RST = 5'h00;
  localparam logic [14:0] PC_RST = 15'h0000;
  // field positions
  localparam int FLAGS_TO = 4;
  localparam int FLAGS_PD = 3;
  localparam int FLAGS_WR_W = 3;
  localparam int BANK_W = 5;
  localparam int LATCH_W = 7;
  localparam int PC_W = 15;
  localparam int INTC_EVT_W = 3;
endpackage : crmb_pkg

// >>> design/crmb_data_ram.sv
// general data memory reached through the indirect ports
`timescale 1ns/1ns
module crmb_data_ram #(
  parameter int DEPTH = 256
) (
  // clock
  input wire logic clk_i,
  // write side
  input wire logic we_i,
  input wire logic [15:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // read side
  input wire logic [15:0] raddr_i,
  output logic [7:0] rdata_o
);
  localparam int AW = $clog2(DEPTH);

  // refuse depths the address mapping cannot serve
  if (DEPTH < 2 || DEPTH > 65536 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("crmb_data_ram: DEPTH must be a power of two up to 65536");
  end

  // storage array, contents undefined after reset
  logic [7:0] mem [DEPTH];
  // addresses beyond the array are not backed
  wire logic w_hit = (32'(waddr_i) < DEPTH);
  wire logic r_hit = (32'(raddr_i) < DEPTH);

  // write port
  always_ff @(posedge clk_i)
  begin
    if (we_i && w_hit)
    begin
      mem[waddr_i[AW-1:0]] <= wdata_i;
    end
  end

  // unbacked addresses read as zero
  assign rdata_o = r_hit ? mem[raddr_i[AW-1:0]] : 8'h00;
endmodule : crmb_data_ram

// >>> design/crmb_pc_unit.sv
// program counter with upper byte fed only from the high latch
`timescale 1ns/1ns
module crmb_pc_unit (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // load from a low-byte write, upper part from the latch
  input wire logic load_i,
  input wire logic [7:0] low_i,
  input wire logic [crmb_pkg::LATCH_W-1:0] latch_i,
  // advance by one instruction
  input wire logic step_i,
  // current counter
  output logic [crmb_pkg::PC_W-1:0] pc_o
);
  logic [crmb_pkg::PC_W-1:0] pc_q;
  logic [crmb_pkg::PC_W-1:0] pc_d;

  // next counter: load beats step
  always_comb
  begin
    pc_d = pc_q;
    if (load_i)
    begin
      pc_d = {latch_i, low_i};
    end
    else if (step_i)
    begin
      pc_d = pc_q + 15'h0001;
    end
  end

  // counter clears on every reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pc_q <= crmb_pkg::PC_RST;
    else
      pc_q <= pc_d;
  end

  assign pc_o = pc_q;
endmodule : crmb_pc_unit

// >>> verif/crmb_checker.sv
// port assertions for the core register bank
`timescale 1ns/1ns
module crmb_checker (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // apb side
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // core state
  input wire logic PC_STEP_I,
  input wire logic [14:0] PC_O,
  input wire logic [4:0] BANK_O,
  input wire logic [7:0] WORK_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // in-bank offset, bank bits ignored
  wire [6:0] ofs = PADDR_I[8:2];
  wire rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
  wire wr_done = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  wire pcl_wr = wr_done && ofs == 7'h02;
  // shadow of the high latch
  logic [6:0] latch_q;
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I) latch_q <= 7'h00;
    else if (wr_done && ofs == 7'h0a) latch_q <= PWDATA_I[6:0];
  end
  AST_NO_ERR: assert property (PSEL_I |-> !PSLVERR_O)
    else $error("slave error raised");
  AST_UNMAPPED_ZERO: assert property
    (rd_setup && ofs >= 7'h0c |=> PRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  AST_LATCH_TOP: assert property
    (rd_setup && ofs == 7'h0a |=> PRDATA_O[31:7] == 25'h0)
    else $error("latch top bit set");
  AST_PC_LOAD: assert property (pcl_wr |=>
    PC_O == {$past(latch_q), $past(PWDATA_I[7:0])})
    else $error("counter load wrong");
  AST_PC_HOLD: assert property
    (!pcl_wr && !PC_STEP_I |=> $stable(PC_O))
    else $error("counter changed without cause");
  AST_BANK_MIRROR: assert property (wr_done && ofs == 7'h08 |=>
    BANK_O == $past(PWDATA_I[4:0]))
    else $error("bank select write lost");
  AST_WORK_MIRROR: assert property (wr_done && ofs == 7'h09 |=>
    WORK_O == $past(PWDATA_I[7:0]))
    else $error("working write lost");
  AST_RESET_PC: assert property
    ($fell(RST_I) |-> PC_O == 15'h0 && BANK_O == 5'h0)
    else $error("reset left counter set");
endmodule : crmb_checker

bind crmb_core_bank crmb_checker u_chk (.CLOCK_I, .RST_I, .PSEL_I,
  .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O,
  .PSLVERR_O, .PC_STEP_I, .PC_O, .BANK_O, .WORK_O);

// >>> verif/tb_core_register_mirror_bank.sv
// self-checking bench for the core register bank
`timescale 1ns/1ns
module tb_core_register_mirror_bank;
  `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
  // drive and observe
  logic clk = 0, rst = 1, por = 1, psel = 0, pen = 0, pwr = 0;
  logic step = 0, tmo = 1, pdn = 0;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready;
  logic [14:0] pc;
  logic [4:0] bank;
  logic [7:0] work;
  logic [7:0] intc;
  logic [2:0] evt = 0;
  int num_errors = 0, n_checks = 0, cyc = 0;
  int unsigned seed = 3;
  // model registers by offset, memory by address
  int m [16];
  int mem [int];
  always #20 clk = ~clk;
  crmb_core_bank u_dut (.CLOCK_I(clk), .RST_I(rst), .POR_I(por),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(), .PC_STEP_I(step), .INT_EVT_I(evt), .TIMEOUT_I(tmo),
    .POWERDOWN_I(pdn), .PC_O(pc), .BANK_O(bank), .WORK_O(work),
    .INTC_O(intc));
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // model read; out-of-range memory reads zero
  function automatic int mrd(int o);
    int a = o ? m[7] * 256 + m[6] : m[5] * 256 + m[4];
    if (o < 2) return (a < 256 && mem.exists(a)) ? mem[a] : 0;
    if (o == 2) return m[2] & 'hff;
    return (o < 12) ? m[o] : 0;
  endfunction : mrd
  // model write with field masks
  function automatic void mwr(int o, int d);
    int a = o ? m[7] * 256 + m[6] : m[5] * 256 + m[4];
    if (o < 2 && a < 256) mem[a] = d;
    else if (o == 2) m[2] = m[10] * 256 + d;
    else if (o == 3) m[3] = m[3] & 'h18 | d & 7;
    else if (o == 8) m[8] = d & 'h1f;
    else if (o == 10) m[10] = d & 'h7f;
    else if (o > 3 && o < 12) m[o] = d;
  endfunction : mwr
  // one apb transfer, then compare with the model
  task automatic op(input bit w, input int bk, input int o, input int d);
    logic [31:0] r;
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= {2'b00, bk[4:0], o[6:0], 2'b00};
    pwdata <= {24'h0, d[7:0]};
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    pen <= 0;
    if (w) mwr(o, d & 'hff);
    else `CHK("prdata", mrd(o), r)
    // events held over the transfer set the low control flags
    m[11] |= evt;
    @(negedge clk);
    `CHK("pc", m[2], pc)
    `CHK("bank", m[8], bank)
    `CHK("work", m[9], work)
    `CHK("intc", m[11], intc)
  endtask : op
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  initial
  begin
    int o;
    repeat (2) @(posedge clk);
    rst <= 0;
    m = '{3: 'h18, default: 0};
    // power-on values, top latch bit zero
    for (int k = 2; k < 16; k++) op(0, 31, k, 0);
    // random writes, read back from an independently drawn random bank
    repeat (60)
    begin
      o = 2 + xs() % 14;
      op(1, xs() % 32, o, xs() % 256);
      op(0, xs() % 32, o, 0);
    end
    // indirect ports share memory, range limit
    op(1, 0, 5, 0);
    op(1, 3, 4, 'h5a);
    op(1, 7, 0, 'hc3);
    op(1, 0, 7, 0);
    op(1, 0, 6, 'h5a);
    op(0, 9, 1, 0);
    op(0, 2, 0, 0);
    op(1, 0, 7, 1);
    op(1, 0, 1, 'h77);
    op(0, 0, 1, 0);
    // counter advance by one
    @(posedge clk) step <= 1;
    @(posedge clk) step <= 0;
    m[2] = (m[2] + 1) & 'h7fff;
    op(0, 5, 2, 0);
    // events set the low control flags, even over a clear
    @(posedge clk) evt <= 3'h5;
    op(1, 4, 11, 'h00);
    @(posedge clk) evt <= 3'h0;
    op(0, 1, 11, 0);
    op(1, 2, 5, 'h3c);
    op(1, 0, 10, 'hff);
    @(posedge clk);
    por <= 0;
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    m[2] = 0;
    m[5] = 0;
    m[7] = 0;
    m[8] = 0;
    m[10] = 0;
    m[11] &= 1;
    m[3] = m[3] & 7 | 8;
    for (int k = 2; k < 12; k++) op(0, 16, k, 0);
    wrap_up();
  end
endmodule : tb_core_register_mirror_bank
